// ===== rtl/dif_cfg.svh
// constants for the digital input function block
// assumes inclusion by dif_pkg and the rtl modules
`ifndef DIF_CFG_SVH
`define DIF_CFG_SVH
`define DIF_NUM_IN          6
`define DIF_CNT_W           32
// function selection codes
`define DIF_FN_NONE         6'h00
`define DIF_FN_CMD_SW       6'h12
`define DIF_FN_CMD_COMM     6'h13
`define DIF_FN_SPD_TRQ      6'h14
`define DIF_FN_TRQ_INH      6'h15
`define DIF_FN_PID_PAUSE    6'h16
`define DIF_FN_INT_PAUSE    6'h17
`define DIF_FN_PID_REV      6'h18
`define DIF_FN_PID_SET      6'h19
`define DIF_FN_SEQ_RST      6'h1A
`define DIF_FN_SWING_PAUSE  6'h1B
`define DIF_FN_CNT_IN       6'h1C
`define DIF_FN_CNT_RST      6'h1D
// command source select values
`define DIF_CMD_PANEL       2'h0
`define DIF_CMD_TERM        2'h1
`define DIF_CMD_COMM        2'h2
// register byte offsets
`define DIF_OFF_CTRL        12'h000
`define DIF_OFF_STAT        12'h004
`define DIF_OFF_COUNT       12'h008
`define DIF_OFF_FSEL0       12'h010
`define DIF_OFF_FSEL5       12'h024
// control field positions
`define DIF_CTRL_CMD_LSB    0
`define DIF_CTRL_MODE_BIT   2
`define DIF_CTRL_DIR_BIT    3
`define DIF_CTRL_GSRC_BIT   4
`define DIF_CTRL_RST        32'h0000_0001
`endif

// ===== rtl/dif_pkg.sv
// types shared by the digital input function block
// assumes dif_cfg.svh is on the include path
`include "dif_cfg.svh"
package dif_pkg;
   typedef logic [5:0] dif_fsel_t;
   typedef struct packed {
      logic [1:0] cmdSrc;
      logic       torqueMode;
      logic       pidPause;
      logic       pidIntPause;
      logic       pidReverse;
      logic       pidGainSet2;
      logic       seqReset;
      logic       swingPause;
   } dif_ctl_t;
endpackage : dif_pkg

// ===== rtl/dif_sync.sv
// two-flop synchroniser with rising-edge pulse, per terminal
// assumes the terminal levels are quasi-static relative to ref_clk
`timescale 1ns/10ps
`include "dif_cfg.svh"
module dif_sync
   import dif_pkg::*;
(
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   // terminals
   input  wire logic [`DIF_NUM_IN-1:0]  termIn,
   output      logic [`DIF_NUM_IN-1:0]  termLvl,
   output      logic [`DIF_NUM_IN-1:0]  termRise
);
   typedef struct packed {
      logic [`DIF_NUM_IN-1:0] s1;
      logic [`DIF_NUM_IN-1:0] s2;
      logic [`DIF_NUM_IN-1:0] s3;
   } dif_sync_st_t;
   dif_sync_st_t st_ff;
   dif_sync_st_t nxt_st;
   always_comb
   begin
      nxt_st    = st_ff;
      nxt_st.s1 = termIn;
      nxt_st.s2 = st_ff.s1;
      nxt_st.s3 = st_ff.s2;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   assign termLvl  = st_ff.s2;
   assign termRise = st_ff.s2 & ~st_ff.s3;
endmodule : dif_sync

// ===== rtl/dif_apb.sv
// apb slave, zero wait state, word registers
// assumes a standard apb master on ref_clk
`timescale 1ns/10ps
module dif_apb
   import dif_pkg::*;
(
   // clock and reset
   input  wire logic          ref_clk,
   input  wire logic          reset_n,
   // apb
   input  wire logic          psel,
   input  wire logic          penable,
   input  wire logic          pwrite,
   input  wire logic [11:0]   paddr,
   input  wire logic [31:0]   pwdata,
   output      logic [31:0]   prdata,
   output      logic          pready,
   output      logic          pslverr,
   // register side
   output      logic          wrStb,
   output      logic [11:0]   wrAddr,
   output      logic [31:0]   wrData,
   input  wire logic [31:0]   rdData,
   input  wire logic          addrOk
);
   typedef struct packed {
      logic [31:0] rdat;
   } dif_apb_st_t;
   dif_apb_st_t st_ff;
   dif_apb_st_t nxt_st;
   always_comb
   begin
      nxt_st = st_ff;
      if (psel && !penable && !pwrite)
         nxt_st.rdat = addrOk ? rdData : 32'h0000_0000;
   end
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
         st_ff <= '0;
      else
         st_ff <= nxt_st;
   end
   assign pready  = 1'b1;
   assign pslverr = psel & penable & ~addrOk;
   assign prdata  = st_ff.rdat;
   assign wrStb   = psel & penable & pwrite & addrOk;
   assign wrAddr  = paddr;
   assign wrData  = pwdata;
endmodule : dif_apb

// ===== rtl/dif_top.sv
// digital input terminal function logic: decodes per-terminal
// function codes and drives mode, pid, sequencer and counter controls
// assumes terminals synchronous to ref_clk, software on apb
//
// Operation
// - terminal-control source toggles terminal/panel
// - switchover input moves terminal to communication
// - speed/torque input selects other mode
// - torque inhibit forces speed control
// - pid pause holds output frequency
// - integral pause freezes integral term only
// - reverse input inverts configured pid direction
// - gain set two while input active
// - sequencer reset returns sequencer to start
// - swing pause outputs central frequency
// - counter pulse advances counter by one
// - counter reset clears counter to zero
`timescale 1ns/10ps
`include "dif_cfg.svh"
module dif_top
   import dif_pkg::*;
(
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    reset_n,
   // apb
   input  wire logic                    psel,
   input  wire logic                    penable,
   input  wire logic                    pwrite,
   input  wire logic [11:0]             paddr,
   input  wire logic [31:0]             pwdata,
   output      logic [31:0]             prdata,
   output      logic                    pready,
   output      logic                    pslverr,
   // digital input terminals
   input  wire logic [`DIF_NUM_IN-1:0]  digitalInputTerminal,
   // drive controls
   output      logic [1:0]              cmdSrcActive,
   output      logic                    torqueModeActive,
   output      logic                    pidPauseOut,
   output      logic                    pidIntPauseOut,
   output      logic                    pidReverseOut,
   output      logic                    pidGainSet2Out,
   output      logic                    seqResetOut,
   output      logic                    swingPauseOut,
   output      logic [`DIF_CNT_W-1:0]   pulseCount
);
   // ***************************************
   // state
   // ***************************************
   typedef struct packed {
      logic [1:0]             commandSourceSelect;
      logic                   controlModeSetting;
      logic                   pidDirectionSetting;
      logic                   pidGainSwitchSource;
      dif_fsel_t [`DIF_NUM_IN-1:0] fsel;
      dif_ctl_t               ctl;
      logic [`DIF_CNT_W-1:0]  count;
   } dif_top_st_t;

   dif_top_st_t                st_ff;
   dif_top_st_t                nxt_st;
   logic [`DIF_NUM_IN-1:0]     termLvl;
   logic [`DIF_NUM_IN-1:0]     termRise;
   logic                       wrStb;
   logic [11:0]                wrAddr;
   logic [31:0]                wrData;
   logic [31:0]                rdData;
   logic                       addrOk;

   // ***************************************
   // helpers
   // ***************************************
   // any terminal assigned code fn whose mask bit is set
   function automatic logic fn_any(input dif_fsel_t [`DIF_NUM_IN-1:0] sel,
                                   input logic [`DIF_NUM_IN-1:0] mask,
                                   input dif_fsel_t fn);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < `DIF_NUM_IN; i++)
         if (sel[i] == fn && mask[i])
            hit = 1'b1;
      return hit;
   endfunction : fn_any

   function automatic logic fsel_hit(input logic [11:0] a);
      return a >= `DIF_OFF_FSEL0 && a <= `DIF_OFF_FSEL5 && a[1:0] == 2'h0;
   endfunction : fsel_hit

   // ***************************************
   // sub-blocks
   // ***************************************
   dif_sync u_sync
   (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .termIn   (digitalInputTerminal),
      .termLvl  (termLvl),
      .termRise (termRise)
   );

   dif_apb u_apb
   (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .psel     (psel),
      .penable  (penable),
      .pwrite   (pwrite),
      .paddr    (paddr),
      .pwdata   (pwdata),
      .prdata   (prdata),
      .pready   (pready),
      .pslverr  (pslverr),
      .wrStb    (wrStb),
      .wrAddr   (wrAddr),
      .wrData   (wrData),
      .rdData   (rdData),
      .addrOk   (addrOk)
   );

   // ***************************************
   // register read decode
   // ***************************************
   logic [2:0] fIdx;
   assign fIdx = 3'((paddr - `DIF_OFF_FSEL0) >> 2);

   always_comb
   begin
      addrOk = 1'b1;
      rdData = 32'h0000_0000;
      if (paddr == `DIF_OFF_CTRL)
         rdData = {27'h0, st_ff.pidGainSwitchSource, st_ff.pidDirectionSetting,
                   st_ff.controlModeSetting, st_ff.commandSourceSelect};
      else if (paddr == `DIF_OFF_STAT)
         rdData = {17'h0, termLvl, st_ff.ctl};
      else if (paddr == `DIF_OFF_COUNT)
         rdData = st_ff.count;
      else if (fsel_hit(paddr))
         rdData = {26'h0, st_ff.fsel[fIdx]};
      else
         addrOk = 1'b0;
   end

   // ***************************************
   // next state
   // ***************************************
   logic [2:0] wIdx;
   logic       cmdToggle;
   logic       commRise;
   logic       cntPulse;
   logic       cntClr;
   logic       swTrq;
   logic       inhTrq;
   assign wIdx = 3'((wrAddr - `DIF_OFF_FSEL0) >> 2);

   always_comb
   begin
      nxt_st    = st_ff;
      // functions decoded from synchronised levels and edges
      cmdToggle = fn_any(st_ff.fsel, termRise, `DIF_FN_CMD_SW);
      commRise  = fn_any(st_ff.fsel, termRise, `DIF_FN_CMD_COMM);
      cntPulse  = fn_any(st_ff.fsel, termRise, `DIF_FN_CNT_IN);
      cntClr    = fn_any(st_ff.fsel, termLvl,  `DIF_FN_CNT_RST);
      swTrq     = fn_any(st_ff.fsel, termLvl,  `DIF_FN_SPD_TRQ);
      inhTrq    = fn_any(st_ff.fsel, termLvl,  `DIF_FN_TRQ_INH);

      if (wrStb)
      begin
         if (wrAddr == `DIF_OFF_CTRL)
         begin
            nxt_st.commandSourceSelect = wrData[`DIF_CTRL_CMD_LSB +: 2];
            nxt_st.controlModeSetting  = wrData[`DIF_CTRL_MODE_BIT];
            nxt_st.pidDirectionSetting = wrData[`DIF_CTRL_DIR_BIT];
            nxt_st.pidGainSwitchSource = wrData[`DIF_CTRL_GSRC_BIT];
            nxt_st.ctl.cmdSrc          = wrData[`DIF_CTRL_CMD_LSB +: 2];
         end
         else if (fsel_hit(wrAddr))
            nxt_st.fsel[wIdx] = wrData[5:0];
      end

      // command source switching from terminals
      if (st_ff.commandSourceSelect == `DIF_CMD_TERM)
      begin
         if (commRise && st_ff.ctl.cmdSrc == `DIF_CMD_TERM)
            nxt_st.ctl.cmdSrc = `DIF_CMD_COMM;
         else if (cmdToggle)
            nxt_st.ctl.cmdSrc = (st_ff.ctl.cmdSrc == `DIF_CMD_TERM) ?
                                `DIF_CMD_PANEL : `DIF_CMD_TERM;
      end

      // torque inhibit outranks the mode switch
      nxt_st.ctl.torqueMode  = inhTrq ? 1'b0 :
                               (st_ff.controlModeSetting ^ swTrq);
      nxt_st.ctl.pidPause    = fn_any(st_ff.fsel, termLvl, `DIF_FN_PID_PAUSE);
      nxt_st.ctl.pidIntPause = fn_any(st_ff.fsel, termLvl, `DIF_FN_INT_PAUSE);
      nxt_st.ctl.pidReverse  = st_ff.pidDirectionSetting ^
                               fn_any(st_ff.fsel, termLvl, `DIF_FN_PID_REV);
      nxt_st.ctl.pidGainSet2 = st_ff.pidGainSwitchSource &
                               fn_any(st_ff.fsel, termLvl, `DIF_FN_PID_SET);
      nxt_st.ctl.seqReset    = fn_any(st_ff.fsel, termLvl, `DIF_FN_SEQ_RST);
      nxt_st.ctl.swingPause  = fn_any(st_ff.fsel, termLvl, `DIF_FN_SWING_PAUSE);

      // clear wins over a pulse in the same cycle
      if (cntClr)
         nxt_st.count = '0;
      else if (cntPulse)
         nxt_st.count = st_ff.count + `DIF_CNT_W'(1);
   end

   // ***************************************
   // registers
   // ***************************************
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         st_ff                     <= '0;
         st_ff.commandSourceSelect <= 2'(`DIF_CTRL_RST);
         st_ff.ctl.cmdSrc          <= 2'(`DIF_CTRL_RST);
      end
      else
         st_ff <= nxt_st;
   end

   assign cmdSrcActive     = st_ff.ctl.cmdSrc;
   assign torqueModeActive = st_ff.ctl.torqueMode;
   assign pidPauseOut      = st_ff.ctl.pidPause;
   assign pidIntPauseOut   = st_ff.ctl.pidIntPause;
   assign pidReverseOut    = st_ff.ctl.pidReverse;
   assign pidGainSet2Out   = st_ff.ctl.pidGainSet2;
   assign seqResetOut      = st_ff.ctl.seqReset;
   assign swingPauseOut    = st_ff.ctl.swingPause;
   assign pulseCount       = st_ff.count;
endmodule : dif_top

// ===== testbench/dif_top_properties.sv
// port checker for the digital input function block
// assumes dif_pkg compiled first, bound to dif_top
`timescale 1ns/10ps
`include "dif_cfg.svh"
module dif_top_check
   import dif_pkg::*;
(
   // clock and reset
   input wire logic                    ref_clk,
   input wire logic                    reset_n,
   // apb
   input wire logic                    psel,
   input wire logic                    penable,
   input wire logic                    pwrite,
   input wire logic [11:0]             paddr,
   input wire logic [31:0]             pwdata,
   input wire logic                    pready,
   input wire logic                    pslverr,
   // terminals and controls
   input wire logic [`DIF_NUM_IN-1:0]  digitalInputTerminal,
   input wire logic [1:0]              cmdSrcActive,
   input wire logic [`DIF_CNT_W-1:0]   pulseCount
);
   // ****************************
   // properties
   // ****************************
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   chk_ready_access: assert property (psel && penable |-> pready) else $error("pready low in access");
   chk_unmapped_err: assert property (psel && penable && paddr == 12'h00C |-> pslverr) else $error("no slave error");
   chk_mapped_ok: assert property (psel && penable && paddr == 12'h000 |-> !pslverr) else $error("bad slave error");
   chk_err_idle: assert property (!(psel && penable) |-> !pslverr) else $error("slave error outside access");
   chk_count_step: assert property ($changed(pulseCount) |-> pulseCount == $past(pulseCount) + 32'h1
      || pulseCount == 32'h0) else $error("counter jump");
   chk_count_quiet: assert property (($stable(digitalInputTerminal))[*5] |-> $stable(pulseCount))
      else $error("counter moved with quiet terminals");
   chk_ctrl_load: assert property (psel && penable && pwrite && paddr == 12'h000
      |=> cmdSrcActive == $past(pwdata[1:0])) else $error("source not loaded");
   chk_reset_vals: assert property (disable iff (1'b0) !reset_n |=> cmdSrcActive == 2'h1 && pulseCount == 32'h0)
      else $error("bad reset values");
endmodule : dif_top_check

bind dif_top dif_top_check u_check (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
   .digitalInputTerminal(digitalInputTerminal), .cmdSrcActive(cmdSrcActive), .pulseCount(pulseCount));

// ===== testbench/dif_switch_model.sv
// switch bank on the input terminals
// assumes requested levels change right after a clock edge
`timescale 1ns/10ps
module dif_switch_model
(
   // clock
   input  wire logic        ref_clk,
   // requested and driven levels
   input  wire logic [5:0]  want,
   output      logic [5:0]  term
);
   // contacts settle one edge after the request
   initial term = 6'h00;
   always @(posedge ref_clk) term <= want;
endmodule : dif_switch_model

// ===== testbench/digital_input_function_logic_test.sv
// self-checking bench for dif_top with a behavioural model
// assumes dif_pkg and the checker compiled first
`timescale 1ns/10ps
`include "dif_cfg.svh"
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin n_fail++; \
   $display("wrong value %s expected %0h seen %0h", nm, e, s); end end
module digital_input_function_logic_test;
   logic ref_clk = 0, reset_n = 0, psel = 0, penable = 0, pwrite = 0, err;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, rd, pulseCount;
   logic pready, pslverr, tqOut, pauseOut, intOut, revOut, gainOut, seqOut, swingOut;
   logic [5:0] want = 6'h00, term;
   logic [1:0] cmdSrcActive;
   int n_fail = 0, n_tests = 0, cyc = 0, ctrl = 1, src = 1, cnt = 0, n;
   int fsel[6] = '{0, 0, 0, 0, 0, 0};
   dif_top uut (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .digitalInputTerminal(term), .cmdSrcActive(cmdSrcActive), .torqueModeActive(tqOut),
      .pidPauseOut(pauseOut), .pidIntPauseOut(intOut), .pidReverseOut(revOut), .pidGainSet2Out(gainOut),
      .seqResetOut(seqOut), .swingPauseOut(swingOut), .pulseCount(pulseCount));
   dif_switch_model u_sw (.ref_clk(ref_clk), .want(want), .term(term));
   initial forever #10 ref_clk = ~ref_clk;
   // ****************************
   // tasks
   // ****************************
   task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   task fs(input int i, input int c);
      fsel[i] = c;
      apb(1'b1, 12'h010 + 12'(4 * i), 32'(c));
   endtask : fs
   task pulse(input int i);
      want[i] <= 1'b1;
      repeat (3) @(posedge ref_clk);
      want[i] <= 1'b0;
      repeat (8) @(posedge ref_clk);
   endtask : pulse
   function automatic int on(input int c);
      on = 0;
      for (int i = 0; i < 6; i++) if (fsel[i] == c && want[i]) on = 1;
   endfunction : on
   task check;
      int tq;
      repeat (6) @(posedge ref_clk);
      tq = ((ctrl >> 2) & 1) ^ on(`DIF_FN_SPD_TRQ);
      if (on(`DIF_FN_TRQ_INH)) tq = 0;
      `CHK("source", src, cmdSrcActive)
      `CHK("torque", tq, tqOut)
      `CHK("pause", on(`DIF_FN_PID_PAUSE), pauseOut)
      `CHK("intpause", on(`DIF_FN_INT_PAUSE), intOut)
      `CHK("reverse", ((ctrl >> 3) & 1) ^ on(`DIF_FN_PID_REV), revOut)
      `CHK("gain", ((ctrl >> 4) & 1) & on(`DIF_FN_PID_SET), gainOut)
      `CHK("seq", on(`DIF_FN_SEQ_RST), seqOut)
      `CHK("swing", on(`DIF_FN_SWING_PAUSE), swingOut)
      `CHK("count", cnt, pulseCount)
   endtask : check
   task results;
      $display("comparisons %0d mismatches %0d", n_tests, n_fail);
      if (n_fail == 0 && n_tests > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask : results
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         results;
      end
   end
   // ****************************
   // main sequence
   // ****************************
   initial
   begin
      void'($urandom(32'h8881CF22));
      repeat (3) @(posedge ref_clk);
      reset_n <= 1'b1;
      check;
      apb(1'b0, 12'h000, 32'h0);
      `CHK("ctrl reset", 32'h1, rd)
      apb(1'b0, 12'h00C, 32'h0);
      `CHK("unmapped err", 1'b1, err)
      apb(1'b1, 12'h008, 32'hFFFF);
      apb(1'b0, 12'h008, 32'h0);
      `CHK("count ro", 32'h0, rd)
      fs(5, `DIF_FN_TRQ_INH);
      for (int c = `DIF_FN_SPD_TRQ; c <= `DIF_FN_SWING_PAUSE; c++)
      begin
         fs(0, c);
         repeat (4)
         begin
            ctrl = ($urandom & 32'h1C) | 1;
            apb(1'b1, 12'h000, 32'(ctrl));
            want <= 6'($urandom) & 6'h27;
            check;
         end
      end
      want <= 6'h00;
      fs(0, 0);
      fs(5, 0);
      fs(1, `DIF_FN_CNT_IN);
      fs(2, `DIF_FN_CNT_RST);
      n = 1 + $urandom % 20;
      repeat (n)
      begin
         pulse(1);
         cnt++;
      end
      check;
      apb(1'b0, 12'h008, 32'h0);
      `CHK("count reg", cnt, rd)
      want[2] <= 1'b1;
      cnt = 0;
      pulse(1);
      check;
      want[2] <= 1'b0;
      pulse(1);
      cnt = 1;
      check;
      fs(3, `DIF_FN_CMD_SW);
      fs(4, `DIF_FN_CMD_COMM);
      pulse(3);
      src = 0;
      check;
      pulse(3);
      src = 1;
      check;
      pulse(4);
      src = 2;
      check;
      ctrl = 0;
      apb(1'b1, 12'h000, 32'h0);
      src = 0;
      pulse(3);
      pulse(4);
      check;
      results;
   end
endmodule : digital_input_function_logic_test
